// ===== wmbi_ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none

module wmbi_ctrl_model
   import wmbi_pkg::*;
(
   // Link toward the device
   output logic             link_strobe,
   output logic [DQ_W-1:0]  dq_drv,
   output logic [LANES-1:0] pin_drv,
   output logic             pin_drv_oe
);
   // ----------------------------------------------------------------
   // Idle levels
   // ----------------------------------------------------------------
   // Strobe parked low between frames, data lines scrambled
   initial begin
      link_strobe = 1'b0;
      dq_drv      = 16'h5a5a;
      pin_drv     = 2'h3;
      pin_drv_oe  = 1'b0;
   end

   // ----------------------------------------------------------------
   // Write burst
   // ----------------------------------------------------------------
   // Eight transfers, each centred on one strobe change of a 125 ns link clock
   task automatic send_burst(input logic [DQ_W*BURST_LEN-1:0]  data,
                             input logic [LANES*BURST_LEN-1:0] flag_n);
      for (int k = 0; k < BURST_LEN; k++) begin
         dq_drv     = data[k*DQ_W +: DQ_W];
         pin_drv    = flag_n[k*LANES +: LANES];
         pin_drv_oe = 1'b1;
         #31.25;
         link_strobe = ~link_strobe;
         #31.25;
      end
      // Released lines no longer hold the last value
      dq_drv     = ~dq_drv;
      pin_drv_oe = 1'b0;
   endtask : send_burst
endmodule : wmbi_ctrl_model

`default_nettype wire

// ===== wmbi_lane.sv
`timescale 1ns/100ps
`default_nettype none

module wmbi_lane
   import wmbi_pkg::*;
(
   // Lane signals
   wmbi_lane_if.lane bus
);

   logic [3:0] zeros;

   // ----------------------------------------------------------------
   // Per lane mask, write inversion and read inversion
   // ----------------------------------------------------------------
   always_comb begin
      zeros = 4'h0;
      for (int i = 0; i < LANE_W; i++) begin
         if (!bus.rd_byte[i]) begin
            zeros = zeros + 4'h1;
         end
      end
      bus.wr_data = bus.wr_byte;
      bus.wr_keep = 1'b1;
      if (bus.mask_en) begin
         bus.wr_keep = bus.wr_flag_n;
      end else if (bus.winv_en && !bus.wr_flag_n) begin
         bus.wr_data = ~bus.wr_byte;
      end
      // With both write options off the flag is never looked at
      bus.rd_data   = bus.rd_byte;
      bus.rd_flag_n = 1'b1;
      if (bus.rinv_en && (zeros > ZERO_LIMIT)) begin
         bus.rd_data   = ~bus.rd_byte;
         bus.rd_flag_n = 1'b0;
      end
   end

endmodule : wmbi_lane

`default_nettype wire

// ===== wmbi_lane_if.sv
`timescale 1ns/100ps
`default_nettype none

interface wmbi_lane_if;
   import wmbi_pkg::*;
   logic [LANE_W-1:0] wr_byte;
   logic              wr_flag_n;
   logic              mask_en;
   logic              winv_en;
   logic              rinv_en;
   logic [LANE_W-1:0] rd_byte;
   logic [LANE_W-1:0] wr_data;
   logic              wr_keep;
   logic [LANE_W-1:0] rd_data;
   logic              rd_flag_n;

   // Lane logic side
   modport lane (
      input  wr_byte, wr_flag_n, mask_en, winv_en, rinv_en, rd_byte,
      output wr_data, wr_keep, rd_data, rd_flag_n
   );
   // Burst control side
   modport core (
      output wr_byte, wr_flag_n, mask_en, winv_en, rinv_en, rd_byte,
      input  wr_data, wr_keep, rd_data, rd_flag_n
   );
endinterface : wmbi_lane_if

`default_nettype wire

// ===== wmbi_pkg.sv
package wmbi_pkg;

   // ----------------------------------------------------------------
   // Data path shape
   // ----------------------------------------------------------------
   localparam int LANES      = 2;
   localparam int LANE_W     = 8;
   localparam int DQ_W       = LANES * LANE_W;
   localparam int BURST_LEN  = 8;
   localparam int BEAT_W     = 3;
   localparam int ADDR_W     = 4;
   localparam int MEM_WORDS  = (2 ** ADDR_W) * BURST_LEN;
   localparam int MR_W       = 16;

   // ----------------------------------------------------------------
   // Mode register five field positions
   // ----------------------------------------------------------------
   localparam int MR5_MASK_BIT = 10;
   localparam int MR5_WINV_BIT = 11;
   localparam int MR5_RINV_BIT = 12;

   // ----------------------------------------------------------------
   // Read inversion threshold and reset values
   // ----------------------------------------------------------------
   localparam logic [3:0]  ZERO_LIMIT  = 4'h4;
   localparam logic [15:0] DQ_RST      = 16'h0000;
   localparam logic [1:0]  PIN_RST     = 2'h3;

   // ----------------------------------------------------------------
   // Timing: one read transfer lasts half a link clock period, rounded down to whole clock cycles (15 cycles, 60 ns)
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_PS  = 4000;
   localparam int LINK_PERIOD_PS = 125000;
   localparam int BEAT_CYCLES    = (LINK_PERIOD_PS / 2) / CLK_PERIOD_PS;
   localparam logic [3:0] BEAT_RELOAD = 4'(BEAT_CYCLES - 1);
   localparam logic [3:0] BURST_DONE  = 4'(BURST_LEN);

   // ----------------------------------------------------------------
   // Burst control states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_WRITE = 3'b010,
      ST_READ  = 3'b100
   } wmbi_state_t;

endpackage : wmbi_pkg

// ===== wmbi_top.sv
`timescale 1ns/100ps
`default_nettype none

module wmbi_top
   import wmbi_pkg::*;
(
   // Clock and reset
   input  wire logic              ref_clk,
   input  wire logic              sys_rst,
   // Mode register five contents
   input  wire logic [MR_W-1:0]   mode_register_five,
   // Core burst requests
   input  wire logic              wr_start,
   input  wire logic [ADDR_W-1:0] wr_addr,
   input  wire logic              rd_start,
   input  wire logic [ADDR_W-1:0] rd_addr,
   output logic                   wr_done,
   output logic                   rd_done,
   // Link from the controller
   input  wire logic              link_strobe,
   input  wire logic [DQ_W-1:0]   dq_in,
   output logic [DQ_W-1:0]        dq_out,
   output logic                   dq_oe,
   output logic                   read_strobe_out,
   // Shared lane mask and inversion pins
   input  wire logic [LANES-1:0]  lane_mask_invert_pin_in,
   output logic [LANES-1:0]       lane_mask_invert_pin_out,
   output logic [LANES-1:0]       lane_mask_invert_pin_oe
);

   localparam int RD_DONE_DLY = 122;

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   logic [DQ_W+LANES:0] sync1;
   logic [DQ_W+LANES:0] sync2;
   logic [DQ_W+LANES:0] sync3;
   logic                strobe_level;
   logic                strobe_edge;
   logic [DQ_W-1:0]     dq_s;
   logic [LANES-1:0]    pin_s;

   // Three stages for strobe, data and lane pins
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sync1 <= '0;
         sync2 <= '0;
         sync3 <= '0;
      end else begin
         sync1 <= {link_strobe, lane_mask_invert_pin_in, dq_in};
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   assign dq_s        = sync3[DQ_W-1:0];
   assign pin_s       = sync3[DQ_W+LANES-1:DQ_W];
   // A strobe change counts once stages two and three agree
   assign strobe_edge = (sync2[DQ_W+LANES] == sync3[DQ_W+LANES]) &&
                        (sync3[DQ_W+LANES] != strobe_level);

   // Last accepted strobe level
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         strobe_level <= 1'b0;
      end else if (strobe_edge) begin
         strobe_level <= sync3[DQ_W+LANES];
      end
   end

   // ----------------------------------------------------------------
   // Burst control
   // ----------------------------------------------------------------
   wmbi_state_t       state;
   logic [2:0]        mode_q;        // read inv, write inv, mask
   logic [ADDR_W-1:0] addr_q;
   logic [BEAT_W-1:0] wr_beat;
   logic [3:0]        rd_cnt;
   logic [3:0]        div_cnt;
   logic              beat_tick;
   logic              wr_beat_en;
   logic              rd_load;

   assign beat_tick  = (state == ST_READ) && (div_cnt == 4'h0);
   assign wr_beat_en = (state == ST_WRITE) && strobe_edge;
   assign rd_load    = beat_tick && (rd_cnt != BURST_DONE);

   // State, mode capture and burst address
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state  <= ST_IDLE;
         mode_q <= 3'h0;
         addr_q <= '0;
      end else begin
         case (state)
            ST_IDLE: begin
               mode_q <= {mode_register_five[MR5_RINV_BIT],
                          mode_register_five[MR5_WINV_BIT],
                          mode_register_five[MR5_MASK_BIT]};
               if (wr_start) begin
                  state  <= ST_WRITE;
                  addr_q <= wr_addr;
               end else if (rd_start) begin
                  state  <= ST_READ;
                  addr_q <= rd_addr;
               end
            end
            ST_WRITE: begin
               if (wr_beat_en && (wr_beat == 3'h7)) begin
                  state <= ST_IDLE;
               end
            end
            ST_READ: begin
               if (beat_tick && (rd_cnt == BURST_DONE)) begin
                  state <= ST_IDLE;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // Transfer counters and read beat divider
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_beat <= '0;
         rd_cnt  <= 4'h0;
         div_cnt <= 4'h0;
      end else if (state == ST_IDLE) begin
         wr_beat <= '0;
         rd_cnt  <= 4'h0;
         div_cnt <= 4'h0;
      end else begin
         if (wr_beat_en) begin
            wr_beat <= wr_beat + 3'h1;
         end
         if (beat_tick) begin
            div_cnt <= BEAT_RELOAD;
            rd_cnt  <= rd_cnt + 4'h1;
         end else if (state == ST_READ) begin
            div_cnt <= div_cnt - 4'h1;
         end
      end
   end

   // Completion pulses
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_done <= 1'b0;
         rd_done <= 1'b0;
      end else begin
         wr_done <= wr_beat_en && (wr_beat == 3'h7);
         rd_done <= beat_tick && (rd_cnt == BURST_DONE);
      end
   end

   // ----------------------------------------------------------------
   // Storage array and lane logic
   // ----------------------------------------------------------------
   logic [DQ_W-1:0]   mem [0:MEM_WORDS-1];
   logic [DQ_W-1:0]   rd_word;
   logic [DQ_W-1:0]   wr_data_v;
   logic [DQ_W-1:0]   rd_data_v;
   logic [LANES-1:0]  keep_v;
   logic [LANES-1:0]  rd_flag_v;

   assign rd_word = mem[{addr_q, rd_cnt[BEAT_W-1:0]}];

   // One lane block per byte lane, each on its own shared pin
   for (genvar gl = 0; gl < LANES; gl++) begin : g_lane
      wmbi_lane_if lif ();
      assign lif.wr_byte   = dq_s[gl*LANE_W +: LANE_W];
      assign lif.wr_flag_n = pin_s[gl];
      assign lif.mask_en   = mode_q[0];
      assign lif.winv_en   = mode_q[1];
      assign lif.rinv_en   = mode_q[2];
      assign lif.rd_byte   = rd_word[gl*LANE_W +: LANE_W];
      assign wr_data_v[gl*LANE_W +: LANE_W] = lif.wr_data;
      assign rd_data_v[gl*LANE_W +: LANE_W] = lif.rd_data;
      assign keep_v[gl]    = lif.wr_keep;
      assign rd_flag_v[gl] = lif.rd_flag_n;
      wmbi_lane u_lane (
         .bus (lif.lane)
      );
   end

   // Byte lane writes; a dropped byte leaves the old contents
   always_ff @(posedge ref_clk) begin
      if (wr_beat_en) begin
         for (int l = 0; l < LANES; l++) begin
            if (keep_v[l]) begin
               mem[{addr_q, wr_beat}][l*LANE_W +: LANE_W] <=
                  wr_data_v[l*LANE_W +: LANE_W];
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Read drivers
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         dq_out                   <= DQ_RST;
         dq_oe                    <= 1'b0;
         read_strobe_out          <= 1'b0;
         lane_mask_invert_pin_out <= PIN_RST;
         lane_mask_invert_pin_oe  <= '0;
      end else if (rd_load) begin
         dq_out                   <= rd_data_v;
         dq_oe                    <= 1'b1;
         read_strobe_out          <= ~read_strobe_out;
         lane_mask_invert_pin_out <= rd_flag_v;
         lane_mask_invert_pin_oe  <= {LANES{mode_q[2]}};
      end else if (state != ST_READ) begin
         dq_oe                    <= 1'b0;
         lane_mask_invert_pin_out <= PIN_RST;
         lane_mask_invert_pin_oe  <= '0;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   sequence rd_begin;
      (state == ST_IDLE) && rd_start && !wr_start;
   endsequence

   sequence rd_first_beat;
      ##1 (state == ST_READ) ##1 dq_oe;
   endsequence

   chk_read_burst_len: assert property (rd_begin |-> ##RD_DONE_DLY rd_done)
      else $error("Read burst did not finish after eight transfers");

   chk_read_first_out: assert property (rd_begin |-> rd_first_beat)
      else $error("Read burst did not drive its first transfer");

   chk_pin_rx_off: assert property (
      wr_beat_en && !mode_q[0] && !mode_q[1] |-> (keep_v == 2'h3) && (wr_data_v == dq_s))
      else $error("Lane pin level used with both write options off");

   chk_mask_drop: assert property (
      wr_beat_en && mode_q[0] && !pin_s[0] |=> mem[$past({addr_q, wr_beat})][7:0] ==
      $past(mem[{addr_q, wr_beat}][7:0]))
      else $error("Masked byte changed the stored contents");

   chk_mask_keep: assert property (
      wr_beat_en && mode_q[0] |-> keep_v == pin_s)
      else $error("Mask flag did not decide the write");

   chk_write_invert: assert property (
      wr_beat_en && !mode_q[0] && mode_q[1] && !pin_s[1] |->
      wr_data_v[15:8] == ~dq_s[15:8])
      else $error("Upper byte not inverted on low flag");

   chk_read_drive_off: assert property (
      (state == ST_READ) && !mode_q[2] |=> lane_mask_invert_pin_oe == 2'h0)
      else $error("Lane pin driven with read inversion off");

   chk_read_inv_ones: assert property (
      dq_oe && lane_mask_invert_pin_oe[0] |-> $countones(dq_out[7:0]) >= 4)
      else $error("Read byte sent with more than four zeros");

   chk_read_flag_low: assert property (
      rd_load && !rd_flag_v[1] |=> !lane_mask_invert_pin_out[1] &&
      dq_out[15:8] == ~$past(rd_word[15:8]))
      else $error("Low read flag without inverted byte");

   chk_mode_capture: assert property (
      (state == ST_IDLE) |=> mode_q[0] == $past(mode_register_five[MR5_MASK_BIT]))
      else $error("Mask enable not taken from mode register five");

endmodule : wmbi_top

`default_nettype wire

// ===== wmbi_top_bench.sv
`timescale 1ns/100ps
`default_nettype none

module wmbi_top_bench;
   import wmbi_pkg::*;
   localparam int TIME_LIMIT = 10000;
   logic              ref_clk, sys_rst, wr_start, rd_start, wr_done, rd_done;
   logic              link_strobe, pin_drv_oe, dq_oe, read_strobe_out, rs_lvl;
   logic [MR_W-1:0]   mode_register_five;
   logic [ADDR_W-1:0] wr_addr, rd_addr;
   logic [DQ_W-1:0]   dq_in, dq_out, dq_drv;
   logic [LANES-1:0]  pin_in, pin_out, pin_oe, pin_drv;
   logic [DQ_W-1:0]   mem [0:MEM_WORDS-1];
   logic [2:0]        wmode_tab [3] = '{3'h0, 3'h1, 3'h2};
   int                err_total, compares, cycles, seed;

   // ----------------------------------------------------------------
   // Clock, wire levels, instances
   // ----------------------------------------------------------------
   initial ref_clk = 1'b0;
   always #2 ref_clk = ~ref_clk;

   // Shared wires: device drive wins, released lane pins are pulled high
   assign dq_in  = dq_oe ? dq_out : dq_drv;
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & (pin_drv_oe ? pin_drv : 2'h3));

   wmbi_top dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .mode_register_five(mode_register_five),
      .wr_start(wr_start), .wr_addr(wr_addr), .rd_start(rd_start), .rd_addr(rd_addr),
      .wr_done(wr_done), .rd_done(rd_done), .link_strobe(link_strobe), .dq_in(dq_in),
      .dq_out(dq_out), .dq_oe(dq_oe), .read_strobe_out(read_strobe_out),
      .lane_mask_invert_pin_in(pin_in), .lane_mask_invert_pin_out(pin_out),
      .lane_mask_invert_pin_oe(pin_oe));

   wmbi_ctrl_model ctrl (.link_strobe(link_strobe), .dq_drv(dq_drv), .pin_drv(pin_drv),
      .pin_drv_oe(pin_drv_oe));

   // ----------------------------------------------------------------
   // Expectations and comparisons
   // ----------------------------------------------------------------
   // Stored byte after one write transfer; masking wins if both are on
   function automatic logic [LANE_W-1:0] wr_lane(input logic [LANE_W-1:0] old_b, new_b,
                                                 input logic fl_n, mask, winv);
      if (mask) return fl_n ? new_b : old_b;
      if (winv) return fl_n ? new_b : ~new_b;
      return new_b;
   endfunction : wr_lane

   // Flag and byte on the wire for one read transfer
   function automatic logic [LANE_W:0] rd_lane(input logic [LANE_W-1:0] b, input logic rinv);
      if (rinv && $countones(~b) > ZERO_LIMIT) return {1'b0, ~b};
      return {1'b1, b};
   endfunction : rd_lane

   task automatic chk_data(input logic [DQ_W-1:0] got, exp, input string what);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk_data

   task automatic chk_flag(input logic [1:0] got, exp, input string what);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %0t %s got %b exp %b", $time, what, got, exp);
      end
   endtask : chk_flag

   task automatic tally_and_finish();
      $display("Counts: %0d compares, %0d errors", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : tally_and_finish

   // Hang guard
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == TIME_LIMIT) begin
         err_total++;
         $display("ERROR %0t run did not complete", $time);
         tally_and_finish();
      end
   end

   // ----------------------------------------------------------------
   // Bursts
   // ----------------------------------------------------------------
   // Write burst with random data and flags; beat 0 is a fixed zero-count corner
   task automatic write_burst(input logic [ADDR_W-1:0] a, input logic [2:0] mode);
      logic [DQ_W*BURST_LEN-1:0]  data;
      logic [LANES*BURST_LEN-1:0] fl;
      logic [DQ_W-1:0]            w;
      logic [DQ_W-1:0]            o;
      int                         n;
      data = {$urandom, $urandom, $urandom, $urandom};
      fl = 16'($urandom);
      data[15:0] = 16'h070f;
      fl[1:0] = 2'h3;
      mode_register_five = (16'($urandom) & 16'he3ff) | {3'h0, mode, 10'h000};
      wr_addr = a;
      wr_start = 1'b1;
      @(posedge ref_clk);
      #1 wr_start = 1'b0;
      fork
         ctrl.send_burst(data, fl);
         begin
            for (n = 0; n < 200; n++) begin
               @(posedge ref_clk);
               #1;
               if (wr_done === 1'b1) break;
            end
            chk_flag(2'(n < 200), 2'h1, "write done");
         end
      join
      for (int k = 0; k < BURST_LEN; k++) begin
         w = data[k*DQ_W +: DQ_W];
         o = mem[{a, 3'(k)}];
         mem[{a, 3'(k)}] = {wr_lane(o[15:8], w[15:8], fl[2*k+1], mode[0], mode[1]),
                            wr_lane(o[7:0], w[7:0], fl[2*k], mode[0], mode[1])};
      end
      @(posedge ref_clk);
      #1;
   endtask : write_burst

   // Read burst; each beat is sampled mid-way through its 15 cycles
   task automatic read_burst(input logic [ADDR_W-1:0] a, input logic rinv);
      logic [LANE_W:0] lo, hi;
      mode_register_five = (16'($urandom) & 16'he3ff) | {3'h0, rinv, 12'h000};
      rd_addr = a;
      rd_start = 1'b1;
      @(posedge ref_clk);
      #1 rd_start = 1'b0;
      for (int k = 0; k < BURST_LEN; k++) begin
         repeat (k == 0 ? 9 : BEAT_CYCLES) @(posedge ref_clk);
         #1;
         rs_lvl = ~rs_lvl;
         lo = rd_lane(mem[{a, 3'(k)}][7:0], rinv);
         hi = rd_lane(mem[{a, 3'(k)}][15:8], rinv);
         chk_data(dq_out, {hi[7:0], lo[7:0]}, "read data");
         chk_flag(pin_out, {hi[8], lo[8]}, "read flag");
         chk_flag(pin_oe, {2{rinv}}, "flag drive");
         chk_flag({dq_oe, read_strobe_out}, {1'b1, rs_lvl}, "read drive");
      end
      repeat (7) @(posedge ref_clk);
      #1;
      chk_flag({rd_done, dq_oe}, 2'h3, "read done");
      @(posedge ref_clk);
      #1;
      chk_flag({rd_done, dq_oe}, 2'h0, "read end");
      chk_flag(pin_oe, 2'h0, "flag release");
   endtask : read_burst

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   // Plain writes first, then masked and inverted overwrites of the same words
   initial begin
      err_total = 0;
      compares = 0;
      cycles = 0;
      rs_lvl = 1'b0;
      sys_rst = 1'b1;
      wr_start = 1'b0;
      rd_start = 1'b0;
      wr_addr = 4'h0;
      rd_addr = 4'h0;
      mode_register_five = 16'h0000;
      seed = $urandom(32'hf181900a);
      repeat (12) @(posedge ref_clk);
      #1 sys_rst = 1'b0;
      chk_data(dq_out, DQ_RST, "reset data");
      chk_flag(pin_out, PIN_RST, "reset flag");
      chk_flag(pin_oe, 2'h0, "reset flag drive");
      chk_flag({dq_oe, read_strobe_out}, 2'h0, "reset drive");
      chk_flag({wr_done, rd_done}, 2'h0, "reset done");
      for (int i = 0; i < 9; i++) begin
         write_burst(4'(i % 3), wmode_tab[i / 3]);
         read_burst(4'(i % 3), i[0]);
      end
      tally_and_finish();
   end
endmodule : wmbi_top_bench

`default_nettype wire
